// [verilog/rst_seq_pkg.sv]
// Constants for the reset latency sequencer
// How it works
// [R1] A system reset or stop-mode recovery holds the processor in reset for 66 oscillator cycles.
// [R2] With the crystal oscillator enabled by option bits the hold grows to 5000 cycles.
// [R3] Power-on and low-voltage resets start counting only once the supply is above threshold.
// [R4] If the external reset pin is still asserted at the end of the count, reset stays on.
// [R5] At reset start every general-purpose pin becomes an input with pull-up off, bar the shared pin.
// [R6] The shared reset pin becomes an open-drain reset, driven low during port reset.
// [R7] During reset the processor and peripherals idle while crystal and watchdog oscillators run; the code runs the crystal only while xtalEnOpt is set.
// [R8] Control registers with defined reset values are loaded; others stay undefined.
// [R9] After release the reset vector is fetched from program addresses 0002H and 0003H.
// [R10] After a system reset the internal oscillator is always the system clock.
// [R11] Stop-mode recovery resets the processor but reloads only watchdog and oscillator control.
// [R12] Software must reprogram the oscillator control to use any other clock source.
// [R13] The hold counter runs on the internal oscillator and releases reset synchronously.
package rst_seq_pkg;
  localparam int unsigned HOLD_SHORT_CYC = 66;
  localparam int unsigned HOLD_XTAL_CYC  = 5000;
  localparam int unsigned CNT_W          = 13;
  localparam logic [15:0] VEC_ADDR_HI    = 16'h0002;
  localparam logic [15:0] VEC_ADDR_LO    = 16'h0003;
  localparam logic [7:0]  OSCILLATOR_CONTROL_REG_RST    = 8'ha0;
  localparam logic [7:0]  WATCHDOG_CONTROL_REG_RST    = 8'h00;
  localparam logic [1:0]  CLKSEL_IPO     = 2'h0;
  typedef enum logic [2:0] {ST_WAIT_SUP, ST_HOLD, ST_PIN, ST_VEC_HI, ST_VEC_LO, ST_RUN}
    seq_state_e;
endpackage

// [verilog/reset_latency_sequencer.sv]
// Reset hold counter, pin state control and reset-vector fetch
`timescale 1ns/10ps
module reset_latency_sequencer
  import rst_seq_pkg::*;
#(
  parameter int unsigned HOLD_XTAL = HOLD_XTAL_CYC,
  parameter int unsigned GPIO_N    = 22
)
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Reset sources
  input  wire logic              sysRstReq,
  input  wire logic              stopRecovery,
  input  wire logic              supplyOk,
  input  wire logic              xtalEnOpt,
  // Shared reset pin
  input  wire logic              sharedResetPinIn,
  output logic                   sharedResetPinOut,
  output logic                   sharedResetPinOe,
  // General pins
  output logic [GPIO_N-1:0]      gpioOutEn,
  output logic [GPIO_N-1:0]      gpioPullUpEn,
  // Program memory
  output logic [15:0]            progAddr,
  output logic                   progRd,
  input  wire logic [7:0]        progData,
  // Processor side
  output logic                   cpuRst,
  output logic                   periphRst,
  output logic                   ctrlRegLoad,
  output logic                   wdtOscCtlLoad,
  output logic [15:0]            pcLoadVal,
  output logic                   pcLoad,
  output logic [1:0]             sysClkSel,
  output logic [7:0]             oscillatorControlRegRst,
  output logic [7:0]             watchdogControlRegRst,
  output logic                   xtalOscRun,
  output logic                   wdtOscRun
);

  // ****************************************
  // Sequence state
  // ****************************************
  seq_state_e      state_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] holdEnd;
  logic [7:0]       vecHi_ff;
  logic             isStop_ff;

  assign holdEnd = xtalEnOpt ? CNT_W'(HOLD_XTAL - 1) : CNT_W'(HOLD_SHORT_CYC - 1); // [R2]

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_ff <= ST_WAIT_SUP;
      cnt_ff   <= '0;
    end
    else if (!supplyOk)
    begin
      state_ff <= ST_WAIT_SUP; // [R3]
      cnt_ff   <= '0;
    end
    else if (sysRstReq || stopRecovery)
    begin
      state_ff <= ST_HOLD; // [R1]
      cnt_ff   <= '0;
    end
    else
    begin
      unique case (state_ff)
        ST_WAIT_SUP: state_ff <= ST_HOLD; // [R3]
        ST_HOLD:
        begin
          if (cnt_ff >= holdEnd) // [R13]
            state_ff <= ST_PIN;
          else
            cnt_ff <= cnt_ff + 1'b1; // [R1]
        end
        ST_PIN:
        begin
          if (sharedResetPinIn) // [R4]
            state_ff <= ST_VEC_HI;
        end
        ST_VEC_HI:   state_ff <= ST_VEC_LO;
        ST_VEC_LO:   state_ff <= ST_RUN;
        ST_RUN:      state_ff <= ST_RUN;
      endcase
    end
  end

  // ****************************************
  // Reset kind and register reload
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      isStop_ff     <= 1'b0;
      ctrlRegLoad   <= 1'b1;
      wdtOscCtlLoad <= 1'b1;
    end
    else
    begin
      if (!supplyOk || sysRstReq)
        isStop_ff <= 1'b0;
      else if (stopRecovery)
        isStop_ff <= 1'b1;
      ctrlRegLoad   <= (!supplyOk || sysRstReq) ||
                       (!isStop_ff && !stopRecovery && state_ff == ST_HOLD); // [R8]
      wdtOscCtlLoad <= !supplyOk || sysRstReq || stopRecovery || state_ff == ST_HOLD; // [R11]
    end
  end

  // ****************************************
  // Pins, clocks and holds
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cpuRst            <= 1'b1;
      periphRst         <= 1'b1;
      gpioOutEn         <= '0;
      gpioPullUpEn      <= '0;
      sharedResetPinOut <= 1'b0;
      sharedResetPinOe  <= 1'b1;
      sysClkSel         <= CLKSEL_IPO;
      xtalOscRun        <= 1'b0;
      wdtOscRun         <= 1'b1;
      oscillatorControlRegRst <= OSCILLATOR_CONTROL_REG_RST;
      watchdogControlRegRst   <= WATCHDOG_CONTROL_REG_RST;
    end
    else
    begin
      cpuRst            <= state_ff != ST_RUN; // [R7]
      periphRst         <= state_ff != ST_RUN; // [R7]
      gpioOutEn         <= '0; // [R5]
      gpioPullUpEn      <= '0; // [R5]
      sharedResetPinOut <= 1'b0; // [R6]
      sharedResetPinOe  <= state_ff == ST_WAIT_SUP || state_ff == ST_HOLD; // [R6]
      sysClkSel         <= CLKSEL_IPO; // [R10]
      xtalOscRun        <= xtalEnOpt; // [R7]
      wdtOscRun         <= 1'b1; // [R7]
      oscillatorControlRegRst <= OSCILLATOR_CONTROL_REG_RST; // [R11]
      watchdogControlRegRst   <= WATCHDOG_CONTROL_REG_RST; // [R11]
    end
  end

  // ****************************************
  // Reset vector fetch
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      progAddr  <= VEC_ADDR_HI;
      progRd    <= 1'b0;
      vecHi_ff  <= 8'h00;
      pcLoadVal <= 16'h0000;
      pcLoad    <= 1'b0;
    end
    else
    begin
      pcLoad <= 1'b0;
      progRd <= 1'b0;
      if (state_ff == ST_PIN && sharedResetPinIn)
      begin
        progAddr <= VEC_ADDR_HI; // [R9]
        progRd   <= 1'b1;
      end
      else if (state_ff == ST_VEC_HI)
      begin
        vecHi_ff <= progData;
        progAddr <= VEC_ADDR_LO; // [R9]
        progRd   <= 1'b1;
      end
      else if (state_ff == ST_VEC_LO)
      begin
        pcLoadVal <= {vecHi_ff, progData}; // [R9]
        pcLoad    <= 1'b1;
      end
    end
  end

endmodule // reset_latency_sequencer

// [testbench/rst_seq_monitor.sv]
// Port checker for the reset latency sequencer
`timescale 1ns/10ps
module rst_seq_monitor
  import rst_seq_pkg::*;
#(parameter int unsigned HOLD_XTAL = 20, parameter int unsigned GPIO_N = 22)
(
  input wire logic clk, sys_rst, sysRstReq, stopRecovery, supplyOk, xtalEnOpt,
  input wire logic sharedResetPinIn, sharedResetPinOut, sharedResetPinOe, progRd,
  input wire logic [GPIO_N-1:0] gpioOutEn, gpioPullUpEn,
  input wire logic [15:0] progAddr,
  input wire logic cpuRst, periphRst, ctrlRegLoad, wdtOscCtlLoad, pcLoad,
  input wire logic [1:0] sysClkSel,
  input wire logic xtalOscRun, wdtOscRun,
  input wire logic [7:0] oscillatorControlRegRst, watchdogControlRegRst
);
  logic [15:0] holdCnt_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Cycles in reset since the last reset source, saturating at ffff
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      holdCnt_ff <= 16'h0;
    else if (sysRstReq || stopRecovery || !supplyOk)
      holdCnt_ff <= 16'h0;
    else if (cpuRst && holdCnt_ff != 16'hffff)
      holdCnt_ff <= holdCnt_ff + 16'h1;
  end
  reg_consts_a: assert property (
    oscillatorControlRegRst == OSCILLATOR_CONTROL_REG_RST && watchdogControlRegRst == WATCHDOG_CONTROL_REG_RST)
    else $error("reload values");
  hold_len_a: assert property (
    $fell(cpuRst) |-> holdCnt_ff >= (xtalEnOpt ? HOLD_XTAL : HOLD_SHORT_CYC)) else $error("short");
  pin_stretch_a: assert property (
    cpuRst && !sharedResetPinIn |=> cpuRst) else $error("left reset, pin low");
  gpio_idle_a: assert property (
    cpuRst |-> !(|{gpioOutEn, gpioPullUpEn})) else $error("gpio driven");
  pin_drive_a: assert property (
    sharedResetPinOe |-> !sharedResetPinOut && cpuRst) else $error("pin drive");
  osc_run_a: assert property (
    cpuRst |-> periphRst && wdtOscRun && xtalOscRun == $past(xtalEnOpt)) else $error("osc");
  stop_regs_a: assert property (
    stopRecovery && !cpuRst |=> ##1 wdtOscCtlLoad && !ctrlRegLoad) else $error("stop regs");
  vec_order_a: assert property (
    progRd && progAddr == VEC_ADDR_HI |=> ##[0:2] progRd && progAddr == VEC_ADDR_LO)
    else $error("vector order");
  clk_release_a: assert property (
    $fell(cpuRst) |-> sysClkSel == CLKSEL_IPO && $past(pcLoad)) else $error("release");
endmodule // rst_seq_monitor
bind reset_latency_sequencer rst_seq_monitor #(.HOLD_XTAL(HOLD_XTAL), .GPIO_N(GPIO_N)) u_mon (.*);

// [testbench/rst_far_side.sv]
// Far side: vector bytes in program memory and the open-drain reset wire
`timescale 1ns/10ps
module rst_far_side (
  input wire logic clk, progRd, pinHoldLow, sharedResetPinOut, sharedResetPinOe,
  input wire logic [15:0] progAddr, vecVal,
  output logic [7:0] progData,
  output logic sharedResetPinIn
);
  // Pulled up unless someone pulls low
  assign sharedResetPinIn = !pinHoldLow && !(sharedResetPinOe && !sharedResetPinOut);
  logic [7:0] vecByte;
  // Read data stands while the read strobe is up, inverse otherwise
  assign vecByte  = (progAddr == 16'h0002) ? vecVal[15:8] : vecVal[7:0];
  assign progData = progRd ? vecByte : ~vecByte;
endmodule // rst_far_side

// [testbench/reset_latency_sequencer_test.sv]
// Self-checking bench for the reset latency sequencer
`timescale 1ns/10ps
module reset_latency_sequencer_test;
  import rst_seq_pkg::*;
  localparam int XT = 20;
  logic clk = 0, sys_rst = 1, sysRstReq = 0, stopRecovery = 0, supplyOk = 0, xtalEnOpt = 0;
  logic pinHoldLow = 0, pinIn, pinOut, pinOe, progRd, pcLoad, cpuRst;
  logic [15:0] progAddr, pcLoadVal, vecVal = 16'h0;
  logic [7:0] progData;
  logic [1:0] sysClkSel;
  int n_fail = 0, checks_done = 0;
  initial forever #12.5 clk = ~clk;
  reset_latency_sequencer #(.HOLD_XTAL(XT)) u_dut (.clk(clk), .sys_rst(sys_rst),
    .sysRstReq(sysRstReq), .stopRecovery(stopRecovery), .supplyOk(supplyOk),
    .xtalEnOpt(xtalEnOpt), .sharedResetPinIn(pinIn), .sharedResetPinOut(pinOut),
    .sharedResetPinOe(pinOe), .gpioOutEn(), .gpioPullUpEn(), .progAddr(progAddr),
    .progRd(progRd), .progData(progData), .cpuRst(cpuRst), .periphRst(), .ctrlRegLoad(),
    .wdtOscCtlLoad(), .pcLoadVal(pcLoadVal), .pcLoad(pcLoad), .sysClkSel(sysClkSel),
    .oscillatorControlRegRst(), .watchdogControlRegRst(), .xtalOscRun(), .wdtOscRun());
  rst_far_side u_far (.clk(clk), .progRd(progRd), .pinHoldLow(pinHoldLow),
    .sharedResetPinOut(pinOut), .sharedResetPinOe(pinOe), .progAddr(progAddr),
    .vecVal(vecVal), .progData(progData), .sharedResetPinIn(pinIn));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e)
    begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic summarize();
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Wait for release; pin let go after s cycles
  task automatic waitRel(input int s, input int lo);
    int n;
    logic [15:0] pcv;
    n = 0;
    pcv = 16'hxxxx;
    while (cpuRst !== 1'b0 && n < 9000)
    begin
      @(posedge clk);
      if (n == s) pinHoldLow <= 1'b0;
      @(negedge clk);
      n++;
      if (pcLoad === 1'b1) pcv = pcLoadVal;
    end
    if (n >= 9000)
    begin
      chk(16'h0, 16'h1);
      summarize();
    end
    else
    begin
      chk(16'(n >= lo && n <= lo + 10), 16'h1);
      chk(pcv, vecVal);
      chk(16'(sysClkSel), 16'(CLKSEL_IPO));
    end
  endtask
  task automatic go(input bit k, input bit x, input int s);
    @(posedge clk);
    xtalEnOpt <= x;
    vecVal <= 16'($urandom);
    pinHoldLow <= (s > 0);
    sysRstReq <= !k;
    stopRecovery <= k;
    @(posedge clk);
    sysRstReq <= 1'b0;
    stopRecovery <= 1'b0;
    // Hold output rises one edge after the request is taken
    @(posedge clk);
    @(negedge clk);
    waitRel(s, (s > 0) ? s : (x ? XT : HOLD_SHORT_CYC));
  endtask
  initial
  begin
    void'($urandom(21506));
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    vecVal <= 16'($urandom);
    repeat (5) @(posedge clk);
    supplyOk <= 1'b1;
    @(negedge clk);
    waitRel(0, HOLD_SHORT_CYC);
    for (int i = 0; i < 8; i++)
    begin
      go(i[0], i[1], i[2] ? (i[1] ? XT : HOLD_SHORT_CYC) + 1 + $urandom_range(30) : 0);
      $display("test %0d end", i);
    end
    summarize();
  end
endmodule // reset_latency_sequencer_test
